// ### core/tdrs_tap.sv
`timescale 1ns/1ns
module tdrs_tap
    import tdrs_pkg::*;
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // test port pins, asynchronous to core_clk
    input wire tdrs_pins_s pins,
    // serial output and its enable
    output tdrs_out_s tdo_pins,
    // observation of controller and parallel stages
    output tdrs_state_e tap_state,
    output logic [7:0] ir_active,
    output logic byp_update
);
    // ------------------------------------------------------------
    // input synchronisers, three stages each
    // ------------------------------------------------------------
    logic [2:0] sync_reg;       // stage 0: tck, 1: tms, 2: tdi
    logic [2:0] sync2_reg;      // second stage
    logic [2:0] sync3_reg;      // third stage
    logic [2:0] sync_next;
    logic [2:0] sync2_next;
    logic [2:0] sync3_next;
    logic tck_lvl_reg;          // accepted test clock level
    logic tck_lvl_next;
    logic rise;                 // accepted rising edge this cycle
    logic fall;                 // accepted falling edge this cycle

    // shift the raw pins through three flops
    always_comb begin
        sync_next = {pins.tdi, pins.tms, pins.tck};
        sync2_next = sync_reg;
        sync3_next = sync2_reg;
        tck_lvl_next = tck_lvl_reg;
        // a level change counts only once stages two and three agree
        if (sync2_reg[0] == sync3_reg[0]) begin
            tck_lvl_next = sync3_reg[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
            tck_lvl_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
            tck_lvl_reg <= tck_lvl_next;
        end
    end

    // tms and tdi lag tck by nothing, so sampling stage three is safe
    assign rise = tck_lvl_next && !tck_lvl_reg;
    assign fall = !tck_lvl_next && tck_lvl_reg;

    // ------------------------------------------------------------
    // controller state and scan registers
    // ------------------------------------------------------------
    tdrs_state_e st_reg;
    tdrs_state_e st_next;
    logic [7:0] ir_sh_reg;      // instruction shift stage
    logic [7:0] ir_sh_next;
    logic [7:0] ir_reg;         // instruction parallel stage
    logic [7:0] ir_next;
    logic byp_reg;              // bypass shift stage
    logic byp_next;
    logic upd_reg;              // bypass parallel stage
    logic upd_next;
    logic tdo_reg;
    logic tdo_next;
    logic oe_reg;
    logic oe_next;
    logic bypass_sel;

    // next controller state on a rising edge, tms as steering bit
    function automatic tdrs_state_e tdrs_step(input tdrs_state_e s, input logic m);
        case (s)
            TDRS_RESET: tdrs_step = m ? TDRS_RESET : TDRS_IDLE;
            TDRS_IDLE: tdrs_step = m ? TDRS_SEL_DR : TDRS_IDLE;
            TDRS_SEL_DR: tdrs_step = m ? TDRS_SEL_IR : TDRS_CAP_DR;
            TDRS_CAP_DR: tdrs_step = m ? TDRS_EXIT1_DR : TDRS_SHIFT_DR;
            TDRS_SHIFT_DR: tdrs_step = m ? TDRS_EXIT1_DR : TDRS_SHIFT_DR;
            TDRS_EXIT1_DR: tdrs_step = m ? TDRS_UPD_DR : TDRS_PAUSE_DR;
            TDRS_PAUSE_DR: tdrs_step = m ? TDRS_EXIT2_DR : TDRS_PAUSE_DR;
            TDRS_EXIT2_DR: tdrs_step = m ? TDRS_UPD_DR : TDRS_SHIFT_DR;
            TDRS_UPD_DR: tdrs_step = m ? TDRS_SEL_DR : TDRS_IDLE;
            TDRS_SEL_IR: tdrs_step = m ? TDRS_RESET : TDRS_CAP_IR;
            TDRS_CAP_IR: tdrs_step = m ? TDRS_EXIT1_IR : TDRS_SHIFT_IR;
            TDRS_SHIFT_IR: tdrs_step = m ? TDRS_EXIT1_IR : TDRS_SHIFT_IR;
            TDRS_EXIT1_IR: tdrs_step = m ? TDRS_UPD_IR : TDRS_PAUSE_IR;
            TDRS_PAUSE_IR: tdrs_step = m ? TDRS_EXIT2_IR : TDRS_PAUSE_IR;
            TDRS_EXIT2_IR: tdrs_step = m ? TDRS_UPD_IR : TDRS_SHIFT_IR;
            TDRS_UPD_IR: tdrs_step = m ? TDRS_SEL_DR : TDRS_IDLE;
            default: tdrs_step = TDRS_RESET;
        endcase
    endfunction : tdrs_step

    // every instruction outside the known set also routes to bypass
    assign bypass_sel = 1'b1;

    // scan and output logic, edges decoded from the synchronised clock
    always_comb begin
        st_next = st_reg;
        ir_sh_next = ir_sh_reg;
        ir_next = ir_reg;
        byp_next = byp_reg;
        upd_next = upd_reg;
        tdo_next = tdo_reg;
        oe_next = oe_reg;
        if (rise) begin
            // three high tms clocks from Update-DR reach reset
            st_next = tdrs_step(st_reg, sync3_reg[1]);
            case (st_reg)
                // capture leaves a zero in the bypass stage
                TDRS_CAP_DR: byp_next = TDRS_BYP_CAPTURE;
                // each shift cycle takes tdi, first one included
                TDRS_SHIFT_DR: byp_next = sync3_reg[2];
                TDRS_CAP_IR: ir_sh_next = TDRS_IR_CAPTURE;
                TDRS_SHIFT_IR: ir_sh_next = {sync3_reg[2], ir_sh_reg[7:1]};
                default: begin
                end
            endcase
        end
        if (fall) begin
            case (st_reg)
                TDRS_SHIFT_DR: begin
                    // drive starts on the first falling edge in shift
                    oe_next = 1'b1;
                    tdo_next = byp_reg;
                end
                TDRS_SHIFT_IR: begin
                    oe_next = 1'b1;
                    tdo_next = ir_sh_reg[0];
                end
                // exit states float the line again
                TDRS_EXIT1_DR: oe_next = 1'b0;
                TDRS_EXIT1_IR: oe_next = 1'b0;
                // parallel stage only moves on the falling edge
                TDRS_UPD_DR: if (bypass_sel) upd_next = byp_reg;
                TDRS_UPD_IR: ir_next = ir_sh_reg;
                TDRS_RESET: ir_next = TDRS_IR_RESET;
                default: oe_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= TDRS_RESET;
            ir_sh_reg <= TDRS_IR_RESET;
            ir_reg <= TDRS_IR_RESET;
            byp_reg <= 1'b0;
            upd_reg <= 1'b0;
            tdo_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            ir_sh_reg <= ir_sh_next;
            ir_reg <= ir_next;
            byp_reg <= byp_next;
            upd_reg <= upd_next;
            tdo_reg <= tdo_next;
            oe_reg <= oe_next;
        end
    end

    // outputs all from flops
    // one driver for the whole bundle, not one per member
    assign tdo_pins = '{tdo: tdo_reg, tdo_oe: oe_reg};
    assign tap_state = st_reg;
    assign ir_active = ir_reg;
    assign byp_update = upd_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    capture_zero_a: assert property ((rise && st_reg == TDRS_CAP_DR) |=> !byp_reg)
        else $error("bypass did not capture zero");
    drive_on_a: assert property ((fall && st_reg == TDRS_SHIFT_DR) |=> oe_reg)
        else $error("tdo not enabled in shift");
    first_bit_a: assert property ((rise && st_reg == TDRS_SHIFT_DR) |=> byp_reg == $past(sync3_reg[2]))
        else $error("first shift bit not sampled");
    delay_path_a: assert property ((fall && st_reg == TDRS_SHIFT_DR) |=> tdo_reg == $past(byp_reg))
        else $error("tdo not one-stage delayed");
    drive_off_a: assert property ((fall && st_reg == TDRS_EXIT1_DR) |=> !oe_reg)
        else $error("tdo not floated in exit1");
    update_fall_a: assert property ((fall && st_reg == TDRS_UPD_DR) |=> upd_reg == $past(byp_reg))
        else $error("update stage not loaded");
    out_on_fall_a: assert property ((!fall) |=> $stable(tdo_reg) && $stable(oe_reg))
        else $error("tdo moved off a falling edge");
    state_on_rise_a: assert property ((!rise) |=> $stable(st_reg))
        else $error("state moved off a rising edge");
    ir_update_a: assert property ((fall && st_reg == TDRS_UPD_IR) |=> ir_reg == $past(ir_sh_reg))
        else $error("instruction not updated");
    reset_walk_a: assert property ((rise && st_reg == TDRS_SEL_IR && sync3_reg[1]) |=> st_reg == TDRS_RESET)
        else $error("reset walk failed");

    shift_seen_c: cover property (st_reg == TDRS_SHIFT_DR && oe_reg);
    update_seen_c: cover property (fall && st_reg == TDRS_UPD_DR);
    bypass_load_c: cover property (fall && st_reg == TDRS_UPD_IR && ir_sh_reg == TDRS_IR_BYPASS);
    back_reset_c: cover property ($past(st_reg) == TDRS_SEL_IR && st_reg == TDRS_RESET);
endmodule : tdrs_tap

// ### core/tdrs_pkg.sv
package tdrs_pkg;
    // ------------------------------------------------------------
    // tap controller states, standard sixteen-state walk
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TDRS_RESET     = 4'h0,
        TDRS_IDLE      = 4'h1,
        TDRS_SEL_DR    = 4'h2,
        TDRS_CAP_DR    = 4'h3,
        TDRS_SHIFT_DR  = 4'h4,
        TDRS_EXIT1_DR  = 4'h5,
        TDRS_PAUSE_DR  = 4'h6,
        TDRS_EXIT2_DR  = 4'h7,
        TDRS_UPD_DR    = 4'h8,
        TDRS_SEL_IR    = 4'h9,
        TDRS_CAP_IR    = 4'ha,
        TDRS_SHIFT_IR  = 4'hb,
        TDRS_EXIT1_IR  = 4'hc,
        TDRS_PAUSE_IR  = 4'hd,
        TDRS_EXIT2_IR  = 4'he,
        TDRS_UPD_IR    = 4'hf
    } tdrs_state_e;

    // ------------------------------------------------------------
    // instruction register layout and values
    // ------------------------------------------------------------
    localparam int TDRS_IR_W = 8;
    localparam logic [7:0] TDRS_IR_CAPTURE = 8'h81;
    localparam logic [7:0] TDRS_IR_BYPASS = 8'hff;
    localparam logic [7:0] TDRS_IR_RESET = 8'hff;
    localparam logic TDRS_BYP_CAPTURE = 1'b0;

    // ------------------------------------------------------------
    // timing: core clock and bench test clock
    // ------------------------------------------------------------
    localparam int TDRS_CORE_PERIOD_NS = 40;
    localparam int TDRS_TCK_PERIOD_NS = 320;
    localparam int TDRS_CORE_PER_TCK = TDRS_TCK_PERIOD_NS / TDRS_CORE_PERIOD_NS;
    localparam int TDRS_RESET_TMS_HIGH = 5;

    // test-port pin bundle into the device
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tdrs_pins_s;

    // serial output bundle from the device
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } tdrs_out_s;
endpackage : tdrs_pkg

// ### verif/tdrs_ctrl_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// test controller model: drives the test clock and serial inputs
// ------------------------------------------------------------
module tdrs_ctrl_model
    import tdrs_pkg::*;
(
    // core clock, only to align pin changes off its sampling edge
    input wire logic core_clk,
    // test port pins toward the device
    output tdrs_pins_s pins
);
    // test clock parks low, it stands still between frames
    initial begin
        pins = '0;
    end

    // one test clock period: the fall carries new tms and tdi
    task automatic step(input logic tms, input logic tdi);
        pins.tck = 1'b0;
        pins.tms = tms;
        pins.tdi = tdi;
        repeat (TDRS_CORE_PER_TCK / 2) @(negedge core_clk);
        pins.tck = 1'b1;
        repeat (TDRS_CORE_PER_TCK / 2) @(negedge core_clk);
    endtask : step

    // final fall of a frame, then a quiet gap so outputs settle
    task automatic park();
        pins.tck = 1'b0;
        repeat (TDRS_CORE_PER_TCK) @(negedge core_clk);
    endtask : park
endmodule : tdrs_ctrl_model

// ### verif/tb_tdrs_tap.sv
`timescale 1ns/1ns
module tb_tdrs_tap;
    import tdrs_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk;
    logic rst_n;
    tdrs_pins_s pins;
    tdrs_out_s tdo_pins;
    tdrs_state_e tap_state;
    logic [7:0] ir_active;
    logic byp_update;
    wire tdo_wire; // floats while the driver is off
    logic exp_q[$]; // tdo bits still due
    int fail_count;
    int tests_run;
    int seed;
    int cycles = 0;
    int n;
    logic [7:0] bits;

    assign tdo_wire = tdo_pins.tdo_oe ? tdo_pins.tdo : 1'bz;

    tdrs_tap i_dut (.core_clk(core_clk), .rst_n(rst_n), .pins(pins), .tdo_pins(tdo_pins),
        .tap_state(tap_state), .ir_active(ir_active), .byp_update(byp_update));
    tdrs_ctrl_model i_ctrl (.core_clk(core_clk), .pins(pins));

    // core clock
    initial begin
        core_clk = 1'b0;
        forever #(TDRS_CORE_PERIOD_NS / 2) core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // watcher: sampled at the fall, before the new bit can land
    always @(negedge pins.tck) begin
        if (tdo_pins.tdo_oe === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("tdo extra bit", 8'h01, 8'h00);
            end else begin
                check("tdo", {7'h00, tdo_wire}, {7'h00, exp_q.pop_front()});
            end
        end
    end

    // hang guard, about eight to ten times the expected run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 86;
        fail_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        // reset clears all synchroniser stages in one edge
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check("state after reset", {4'h0, tap_state}, {4'h0, TDRS_RESET});
        check("ir after reset", ir_active, TDRS_IR_RESET);
        check("oe after reset", {7'h00, tdo_pins.tdo_oe}, 8'h00);
        $display("test reset done");
        // instruction scans: a random value that is not all ones, then all ones,
        // so the update is seen to move away from the reset value and back
        for (int p = 0; p < 2; p++) begin
            bits = (p == 0) ? (8'($random(seed)) & 8'h7f) : TDRS_IR_BYPASS;
            // from reset tms goes 0,1,1,0,0; from Select-DR only 1,0,0
            for (int i = (p == 0) ? 0 : 2; i < 5; i++) begin
                i_ctrl.step(i == 1 || i == 2, 1'b0);
            end
            for (int i = 0; i < 8; i++) begin
                exp_q.push_back(TDRS_IR_CAPTURE[i]);
                i_ctrl.step(i == 7, bits[i]);
            end
            i_ctrl.step(1'b1, 1'b0);
            i_ctrl.step(1'b1, 1'b0);
            i_ctrl.park();
            check("ir after update", ir_active, bits);
            check("state select", {4'h0, tap_state}, {4'h0, TDRS_SEL_DR});
            check("ir tdo left over", 8'(exp_q.size()), 8'h00);
            $display("test ir scan %0d done", p);
        end
        // data scans: 101 first, then one bit, then random lengths
        for (int k = 0; k < 5; k++) begin
            n = (k == 0) ? 3 : (k == 1) ? 1 : 2 + (($random(seed) & 32'h7) % 7);
            bits = (k == 0) ? 8'h05 : 8'($random(seed));
            i_ctrl.step(1'b0, 1'b0);
            i_ctrl.step(1'b0, 1'b0);
            exp_q.push_back(TDRS_BYP_CAPTURE);
            for (int i = 0; i < n; i++) begin
                if (i < n - 1) exp_q.push_back(bits[i]);
                i_ctrl.step(i == n - 1, bits[i]);
            end
            i_ctrl.park();
            check("oe in exit1", {7'h00, tdo_pins.tdo_oe}, 8'h00);
            check("state exit1", {4'h0, tap_state}, {4'h0, TDRS_EXIT1_DR});
            i_ctrl.step(1'b1, 1'b0);
            i_ctrl.step(1'b1, 1'b0);
            i_ctrl.park();
            check("bypass update", {7'h00, byp_update}, {7'h00, bits[n - 1]});
            check("tdo left over", 8'(exp_q.size()), 8'h00);
            $display("test dr scan of %0d bits done", n);
        end
        // two more highs after Select-DR end the test operation
        i_ctrl.step(1'b1, 1'b0);
        i_ctrl.step(1'b1, 1'b0);
        i_ctrl.park();
        check("state at end", {4'h0, tap_state}, {4'h0, TDRS_RESET});
        $display("test return to reset done");
        summarize();
    end
endmodule : tb_tdrs_tap
